// [rtl/operand_address_and_constant_gen.sv]
`timescale 1ns/1ps
module operand_address_and_constant_gen (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire logic [3:0] src_reg,
  input wire opgen_pkg::src_mode_t source_mode_field,
  input wire logic [3:0] dst_reg,
  input wire logic dst_mode,
  input wire opgen_pkg::width_t op_width,
  input wire logic extended,
  input wire logic [3:0] src_index_hi,
  input wire logic [15:0] src_word,
  input wire logic [3:0] dst_index_hi,
  input wire logic [15:0] dst_word,
  input wire logic wr_valid,
  input wire logic [3:0] wr_reg,
  input wire opgen_pkg::width_t wr_width,
  input wire logic sign_extend_op,
  input wire logic [19:0] wr_data,
  output logic resp_valid,
  output opgen_pkg::operand_kind_t src_kind,
  output logic [19:0] src_value,
  output logic [19:0] src_addr,
  output opgen_pkg::operand_kind_t dst_kind,
  output logic [19:0] dst_value,
  output logic [19:0] dst_addr,
  output logic [19:0] pc_value,
  output logic [15:0] flags_word
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [opgen_pkg::NREGS-1:0][19:0] regs;
    logic resp_valid;
    opgen_pkg::operand_kind_t src_kind;
    logic [19:0] src_value;
    logic [19:0] src_addr;
    opgen_pkg::operand_kind_t dst_kind;
    logic [19:0] dst_value;
    logic [19:0] dst_addr;
  } state_t;

  state_t q;
  state_t d;

  // ==========================================================
  // address adders for both operands
  addr_calc_if src_ac ();
  addr_calc_if dst_ac ();

  index_addr_calc u_src_calc (
    .ac(src_ac.calc)
  );

  index_addr_calc u_dst_calc (
    .ac(dst_ac.calc)
  );

  logic [19:0] src_reg_val;
  logic [19:0] dst_reg_val;
  logic is_src_cg1;
  logic is_src_cg2;

  assign src_reg_val = q.regs[src_reg];
  assign dst_reg_val = q.regs[dst_reg];
  assign is_src_cg1 = (src_reg == opgen_pkg::REG_CG1);
  assign is_src_cg2 = (src_reg == opgen_pkg::REG_CG2);

  // the status word slot reads as a zero base, which turns indexed into absolute
  assign src_ac.base = is_src_cg1 ? opgen_pkg::CONST_ZERO : src_reg_val;
  assign src_ac.index_lo = src_word;
  assign src_ac.index_hi = src_index_hi;
  assign src_ac.extended = extended;

  assign dst_ac.base = (dst_reg == opgen_pkg::REG_CG1) ? opgen_pkg::CONST_ZERO : dst_reg_val;
  assign dst_ac.index_lo = dst_word;
  assign dst_ac.index_hi = dst_index_hi;
  assign dst_ac.extended = extended;

  // ==========================================================
  // next state
  logic [19:0] immediate;
  logic [19:0] wr_fill;

  always_comb begin
    d = q;
    immediate = extended ? {src_index_hi, src_word} : {{opgen_pkg::HI_W{1'b0}}, src_word};
    wr_fill = opgen_pkg::fit_width(wr_data, wr_width);
    if (sign_extend_op) begin
      wr_fill = {{(opgen_pkg::ADDR_W - opgen_pkg::BYTE_W){wr_data[opgen_pkg::SIGN_BIT_BYTE]}},
                 wr_data[opgen_pkg::BYTE_W-1:0]};
    end
    d.resp_valid = req_valid;
    if (req_valid) begin
      // source operand
      case (source_mode_field)
        opgen_pkg::MODE_REG: begin
          if (is_src_cg2) begin
            d.src_kind = opgen_pkg::KIND_CONST;
            d.src_value = opgen_pkg::CONST_ZERO;
          end else begin
            d.src_kind = opgen_pkg::KIND_REG;
            d.src_value = opgen_pkg::fit_width(src_reg_val, op_width);
          end
          d.src_addr = opgen_pkg::CONST_ZERO;
        end
        opgen_pkg::MODE_INDEXED: begin
          if (is_src_cg2) begin
            d.src_kind = opgen_pkg::KIND_CONST;
            d.src_value = opgen_pkg::CONST_ONE;
            d.src_addr = opgen_pkg::CONST_ZERO;
          end else begin
            d.src_kind = opgen_pkg::KIND_MEM;
            d.src_value = opgen_pkg::CONST_ZERO;
            d.src_addr = src_ac.addr;
          end
        end
        opgen_pkg::MODE_INDIRECT: begin
          d.src_addr = opgen_pkg::CONST_ZERO;
          d.src_value = opgen_pkg::CONST_ZERO;
          d.src_kind = opgen_pkg::KIND_CONST;
          if (is_src_cg1) begin
            d.src_value = opgen_pkg::CONST_FOUR;
          end else if (is_src_cg2) begin
            d.src_value = opgen_pkg::CONST_TWO;
          end else begin
            d.src_kind = opgen_pkg::KIND_MEM;
            d.src_addr = src_reg_val;
          end
        end
        default: begin
          d.src_addr = opgen_pkg::CONST_ZERO;
          d.src_kind = opgen_pkg::KIND_CONST;
          if (is_src_cg1) begin
            d.src_value = opgen_pkg::CONST_EIGHT;
          end else if (is_src_cg2) begin
            d.src_value = opgen_pkg::fit_width(opgen_pkg::ALL_ONES, op_width);
          end else if (src_reg == opgen_pkg::REG_PC) begin
            // instruction words are whole words, so the PC always steps by two
            d.src_value = opgen_pkg::fit_width(immediate, op_width);
            d.src_addr = src_reg_val;
            d.regs[opgen_pkg::REG_PC] = src_reg_val + opgen_pkg::STEP_PC;
          end else begin
            d.src_kind = opgen_pkg::KIND_MEM;
            d.src_value = opgen_pkg::CONST_ZERO;
            d.src_addr = src_reg_val;
            d.regs[src_reg] = src_reg_val + opgen_pkg::step_for(op_width);
          end
        end
      endcase
      // destination operand: only register or indexed
      if (dst_mode) begin
        d.dst_kind = opgen_pkg::KIND_MEM;
        d.dst_addr = dst_ac.addr;
        d.dst_value = opgen_pkg::CONST_ZERO;
      end else begin
        d.dst_kind = opgen_pkg::KIND_REG;
        d.dst_addr = opgen_pkg::CONST_ZERO;
        d.dst_value = opgen_pkg::fit_width(dst_reg_val, op_width);
      end
    end
    // a writeback in the same cycle as an autoincrement of the same register wins
    if (wr_valid && wr_reg != opgen_pkg::REG_CG2) begin
      d.regs[wr_reg] = wr_fill;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign resp_valid = q.resp_valid;
  assign src_kind = q.src_kind;
  assign src_value = q.src_value;
  assign src_addr = q.src_addr;
  assign dst_kind = q.dst_kind;
  assign dst_value = q.dst_value;
  assign dst_addr = q.dst_addr;
  assign pc_value = q.regs[opgen_pkg::REG_PC];
  assign flags_word = q.regs[opgen_pkg::REG_CG1][opgen_pkg::WORD_W-1:0];

  // ==========================================================
  // checks
  a_resp_follows_req: assert property (@(posedge clk) disable iff (!arst_n)
    req_valid |=> resp_valid)
    else $error("response did not follow request");

  a_cg1_four_eight: assert property (@(posedge clk) disable iff (!arst_n)
    req_valid && is_src_cg1 && source_mode_field[1] |=>
      src_kind == opgen_pkg::KIND_CONST &&
      src_value == ($past(source_mode_field[0]) ? opgen_pkg::CONST_EIGHT : opgen_pkg::CONST_FOUR))
    else $error("constant register one gave wrong value");

  a_cg2_all_ones: assert property (@(posedge clk) disable iff (!arst_n)
    req_valid && is_src_cg2 && source_mode_field == opgen_pkg::MODE_AUTOINC |=>
      src_value == opgen_pkg::fit_width(opgen_pkg::ALL_ONES, $past(op_width)))
    else $error("minus one not sized to width");

  a_absolute_zero_base: assert property (@(posedge clk) disable iff (!arst_n)
    req_valid && is_src_cg1 && source_mode_field == opgen_pkg::MODE_INDEXED && !extended |=>
      src_kind == opgen_pkg::KIND_MEM && src_addr == {4'h0, $past(src_word)})
    else $error("absolute address not the next word");

  a_cg2_never_held: assert property (@(posedge clk) disable iff (!arst_n)
    q.regs[opgen_pkg::REG_CG2] == opgen_pkg::CONST_ZERO)
    else $error("constant register two took a value");

  a_byte_write_clear: assert property (@(posedge clk) disable iff (!arst_n)
    wr_valid && wr_width == opgen_pkg::WID_BYTE && !sign_extend_op && wr_reg == 4'h4 |=>
      q.regs[4][19:8] == 12'h000 && q.regs[4][7:0] == $past(wr_data[7:0]))
    else $error("byte write left upper bits");

  a_sxt_fill: assert property (@(posedge clk) disable iff (!arst_n)
    wr_valid && sign_extend_op && wr_reg == 4'h5 |=>
      q.regs[5][19:8] == {12{$past(wr_data[7])}})
    else $error("sign extension wrong");

  a_byte_reg_read: assert property (@(posedge clk) disable iff (!arst_n)
    req_valid && source_mode_field == opgen_pkg::MODE_REG && !is_src_cg2 &&
      op_width == opgen_pkg::WID_BYTE |=>
      src_value == {12'h000, $past(src_reg_val[7:0])})
    else $error("byte register read wrong");

  a_autoinc_step: assert property (@(posedge clk) disable iff (!arst_n)
    req_valid && source_mode_field == opgen_pkg::MODE_AUTOINC && src_reg == 4'h6 &&
      !(wr_valid && wr_reg == 4'h6) |=>
      q.regs[6] == $past(src_reg_val) + opgen_pkg::step_for($past(op_width)))
    else $error("autoincrement step wrong");

  a_low_region_index: assert property (@(posedge clk) disable iff (!arst_n)
    req_valid && source_mode_field == opgen_pkg::MODE_INDEXED && !extended &&
      !is_src_cg2 && src_ac.base[19:16] == 4'h0 |=> src_addr[19:16] == 4'h0)
    else $error("low region address escaped");

endmodule : operand_address_and_constant_gen

// [rtl/opgen_pkg.sv]
package opgen_pkg;

  // ==========================================================
  // widths and register numbers
  localparam int ADDR_W = 20;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int HI_W = 4;
  localparam int NREGS = 16;
  localparam int SIGN_BIT_BYTE = 7;
  localparam logic [3:0] REG_PC = 4'h0;
  localparam logic [3:0] REG_CG1 = 4'h2;
  localparam logic [3:0] REG_CG2 = 4'h3;
  localparam logic [3:0] LOW_REGION_TAG = 4'h0;

  // ==========================================================
  // generated constants, masks and pointer steps
  localparam logic [19:0] CONST_ZERO = 20'h00000;
  localparam logic [19:0] CONST_ONE = 20'h00001;
  localparam logic [19:0] CONST_TWO = 20'h00002;
  localparam logic [19:0] CONST_FOUR = 20'h00004;
  localparam logic [19:0] CONST_EIGHT = 20'h00008;
  localparam logic [19:0] ALL_ONES = 20'hFFFFF;
  localparam logic [19:0] MASK_BYTE = 20'h000FF;
  localparam logic [19:0] MASK_WORD = 20'h0FFFF;
  localparam logic [19:0] STEP_BYTE = 20'h00001;
  localparam logic [19:0] STEP_WORD = 20'h00002;
  localparam logic [19:0] STEP_AWORD = 20'h00004;
  localparam logic [19:0] STEP_PC = 20'h00002;

  // ==========================================================
  // encodings
  typedef enum logic [1:0] {
    MODE_REG = 2'h0,
    MODE_INDEXED = 2'h1,
    MODE_INDIRECT = 2'h2,
    MODE_AUTOINC = 2'h3
  } src_mode_t;

  typedef enum logic [1:0] {
    WID_BYTE = 2'h0,
    WID_WORD = 2'h1,
    WID_AWORD = 2'h3
  } width_t;

  typedef enum logic [1:0] {
    KIND_REG = 2'h0,
    KIND_MEM = 2'h1,
    KIND_CONST = 2'h3
  } operand_kind_t;

  // ==========================================================
  // helpers
  function automatic logic [19:0] fit_width(logic [19:0] v, width_t w);
    case (w)
      WID_BYTE: fit_width = v & MASK_BYTE;
      WID_WORD: fit_width = v & MASK_WORD;
      default: fit_width = v;
    endcase
  endfunction : fit_width

  function automatic logic [19:0] step_for(width_t w);
    case (w)
      WID_BYTE: step_for = STEP_BYTE;
      WID_WORD: step_for = STEP_WORD;
      default: step_for = STEP_AWORD;
    endcase
  endfunction : step_for

endpackage : opgen_pkg

// [rtl/addr_calc_if.sv]
`timescale 1ns/1ps
interface addr_calc_if;
  logic [19:0] base;
  logic [15:0] index_lo;
  logic [3:0] index_hi;
  logic extended;
  logic [19:0] addr;
  modport calc (input base, input index_lo, input index_hi, input extended, output addr);
  modport user (output base, output index_lo, output index_hi, output extended, input addr);
endinterface : addr_calc_if

// [rtl/index_addr_calc.sv]
`timescale 1ns/1ps
module index_addr_calc (
  addr_calc_if.calc ac
);

  // ==========================================================
  // effective address of indexed, symbolic and absolute operands
  logic [19:0] sext_index;
  logic [19:0] sum;

  always_comb begin
    sext_index = {{opgen_pkg::HI_W{ac.index_lo[opgen_pkg::WORD_W-1]}}, ac.index_lo};
    // sums wrap at 20 bits, or at 16 bits off a low-region base when not extended; no error is raised
    if (ac.extended) begin
      sum = ac.base + {ac.index_hi, ac.index_lo};
    end else if (ac.base[19:16] == opgen_pkg::LOW_REGION_TAG) begin
      sum = ac.base + sext_index;
      sum = sum & opgen_pkg::MASK_WORD;
    end else begin
      sum = ac.base + sext_index;
    end
  end

  assign ac.addr = sum;

endmodule : index_addr_calc

// [test/decoder_model.sv]
`timescale 1ns/1ps
// ==========================================================
// decoder and writeback side: holds fields between transfers
module decoder_model (
  input wire logic clk,
  output logic req_valid,
  output logic [3:0] src_reg,
  output opgen_pkg::src_mode_t source_mode_field,
  output logic [3:0] dst_reg,
  output logic dst_mode,
  output opgen_pkg::width_t op_width,
  output logic extended,
  output logic [3:0] src_index_hi,
  output logic [15:0] src_word,
  output logic [3:0] dst_index_hi,
  output logic [15:0] dst_word,
  output logic wr_valid,
  output logic [3:0] wr_reg,
  output opgen_pkg::width_t wr_width,
  output logic sign_extend_op,
  output logic [19:0] wr_data
);
  initial begin
    {req_valid, src_reg, dst_reg, dst_mode, extended, src_index_hi, src_word} = '0;
    {dst_index_hi, dst_word, wr_valid, wr_reg, sign_extend_op, wr_data} = '0;
    source_mode_field = opgen_pkg::MODE_REG;
    op_width = opgen_pkg::WID_WORD;
    wr_width = opgen_pkg::WID_WORD;
  end

  task automatic dst(input logic [3:0] r, input logic m, input logic [3:0] hi,
                     input logic [15:0] wd);
    @(posedge clk);
    dst_reg <= r;
    dst_mode <= m;
    dst_index_hi <= hi;
    dst_word <= wd;
  endtask : dst

  // one-cycle pulse; outputs are settled 1 ns after the answering edge
  task automatic req(input logic [3:0] r, input opgen_pkg::src_mode_t m,
                     input opgen_pkg::width_t w, input logic ext, input logic [3:0] hi,
                     input logic [15:0] wd);
    @(posedge clk);
    req_valid <= 1'b1;
    src_reg <= r;
    source_mode_field <= m;
    op_width <= w;
    extended <= ext;
    src_index_hi <= hi;
    src_word <= wd;
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
  endtask : req

  task automatic wr(input logic [3:0] r, input opgen_pkg::width_t w, input logic sx,
                    input logic [19:0] d);
    @(posedge clk);
    wr_valid <= 1'b1;
    wr_reg <= r;
    wr_width <= w;
    sign_extend_op <= sx;
    wr_data <= d;
    @(posedge clk);
    wr_valid <= 1'b0;
  endtask : wr
endmodule : decoder_model

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
  localparam opgen_pkg::width_t WB = opgen_pkg::WID_BYTE;
  localparam opgen_pkg::width_t WW = opgen_pkg::WID_WORD;
  localparam opgen_pkg::width_t WA = opgen_pkg::WID_AWORD;
  localparam logic [19:0] KR = 20'(opgen_pkg::KIND_REG);
  localparam logic [19:0] KM = 20'(opgen_pkg::KIND_MEM);
  localparam logic [19:0] KC = 20'(opgen_pkg::KIND_CONST);
  logic clk, arst_n, req_valid, dst_mode, extended, wr_valid, sign_extend_op, resp_valid;
  logic [3:0] src_reg, dst_reg, src_index_hi, dst_index_hi, wr_reg;
  logic [15:0] src_word, dst_word, flags_word;
  logic [19:0] wr_data, src_value, src_addr, dst_value, dst_addr, pc_value;
  opgen_pkg::src_mode_t source_mode_field;
  opgen_pkg::width_t op_width, wr_width;
  opgen_pkg::operand_kind_t src_kind, dst_kind;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  opgen_pkg::width_t wl [3] = '{WB, WW, WA};
  logic [19:0] ones [3] = '{20'h000FF, 20'h0FFFF, 20'hFFFFF};

  decoder_model u_decoder_model (.clk, .req_valid, .src_reg, .source_mode_field, .dst_reg,
    .dst_mode, .op_width, .extended, .src_index_hi, .src_word, .dst_index_hi, .dst_word,
    .wr_valid, .wr_reg, .wr_width, .sign_extend_op, .wr_data);
  operand_address_and_constant_gen u_operand_address_and_constant_gen (.clk, .arst_n,
    .req_valid, .src_reg, .source_mode_field, .dst_reg, .dst_mode, .op_width, .extended,
    .src_index_hi, .src_word, .dst_index_hi, .dst_word, .wr_valid, .wr_reg, .wr_width,
    .sign_extend_op, .wr_data, .resp_valid, .src_kind, .src_value, .src_addr, .dst_kind,
    .dst_value, .dst_addr, .pc_value, .flags_word);

  // ==========================================================
  // checking and closing
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    if (errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // register-mode read of a register at the given width
  task automatic rd(input logic [3:0] r, input opgen_pkg::width_t w, input logic [19:0] e);
    u_decoder_model.req(r, opgen_pkg::MODE_REG, w, 1'b0, 4'h0, 16'h0000);
    chk(src_value, e);
    chk(20'(src_kind), KR);
    chk(20'(resp_valid), 20'h00001);
  endtask : rd

  // ==========================================================
  // scenarios
  task automatic t_width();
    u_decoder_model.wr(4'hF, WA, 1'b0, 20'hABCDE);
    rd(4'hF, WA, 20'hABCDE);
    rd(4'hF, WB, 20'h000DE);
    rd(4'hF, WA, 20'hABCDE);
    u_decoder_model.wr(4'h5, WW, 1'b0, 20'hABCDE);
    rd(4'h5, WA, 20'h0BCDE);
    u_decoder_model.wr(4'h5, WB, 1'b0, 20'hABCDE);
    rd(4'h5, WA, 20'h000DE);
    u_decoder_model.wr(4'h5, WB, 1'b1, 20'h00080);
    rd(4'h5, WA, 20'hFFF80);
    u_decoder_model.wr(4'h5, WB, 1'b1, 20'hFFF7F);
    rd(4'h5, WA, 20'h0007F);
    u_decoder_model.wr(4'h3, WA, 1'b0, 20'h12345);
    u_decoder_model.req(4'h3, opgen_pkg::MODE_REG, WA, 1'b0, 4'h0, 16'h0000);
    chk(src_value, 20'h00000);
  endtask : t_width

  task automatic t_const();
    logic [19:0] e [4];
    for (int w = 0; w < 3; w++) begin
      e = '{20'h00000, 20'h00001, 20'h00002, ones[w]};
      for (int m = 0; m < 4; m++) begin
        u_decoder_model.req(4'h3, opgen_pkg::src_mode_t'(m), wl[w], 1'b0, 4'h0, 16'h0000);
        chk(src_value, e[m]);
        chk(20'(src_kind), KC);
      end
    end
    u_decoder_model.req(4'h2, opgen_pkg::MODE_INDIRECT, WW, 1'b0, 4'h0, 16'h0000);
    chk(src_value, 20'h00004);
    chk(20'(src_kind), KC);
    u_decoder_model.req(4'h2, opgen_pkg::MODE_AUTOINC, WW, 1'b0, 4'h0, 16'h0000);
    chk(src_value, 20'h00008);
    u_decoder_model.wr(4'h2, WW, 1'b0, 20'h00155);
    rd(4'h2, WW, 20'h00155);
    chk(20'(flags_word), 20'h00155);
    u_decoder_model.req(4'h2, opgen_pkg::MODE_INDEXED, WW, 1'b0, 4'h0, 16'h8234);
    chk(src_addr, 20'h08234);
    chk(20'(src_kind), KM);
  endtask : t_const

  task automatic t_index();
    u_decoder_model.wr(4'h5, WA, 1'b0, 20'h0479C);
    u_decoder_model.wr(4'h6, WA, 1'b0, 20'h01778);
    u_decoder_model.dst(4'h6, 1'b1, 4'h0, 16'hF000);
    u_decoder_model.req(4'h5, opgen_pkg::MODE_INDEXED, WB, 1'b0, 4'h0, 16'h1000);
    chk(src_addr, 20'h0579C);
    chk(dst_addr, 20'h00778);
    chk(20'(dst_kind), KM);
    u_decoder_model.wr(4'h5, WA, 1'b0, 20'h23456);
    u_decoder_model.req(4'h5, opgen_pkg::MODE_INDEXED, WW, 1'b0, 4'h0, 16'h8346);
    chk(src_addr, 20'h1B79C);
    u_decoder_model.wr(4'h6, WA, 1'b0, 20'h45678);
    u_decoder_model.dst(4'h6, 1'b1, 4'h3, 16'h2100);
    u_decoder_model.req(4'h5, opgen_pkg::MODE_INDEXED, WA, 1'b1, 4'h1, 16'h2346);
    chk(src_addr, 20'h3579C);
    chk(dst_addr, 20'h77778);
    rd(4'h5, WA, 20'h23456);
    u_decoder_model.wr(4'h5, WA, 1'b0, 20'hFFFF0);
    u_decoder_model.req(4'h5, opgen_pkg::MODE_INDEXED, WA, 1'b1, 4'h0, 16'h0020);
    chk(src_addr, 20'h00010);
    u_decoder_model.wr(4'h0, WA, 1'b0, 20'h2F036);
    u_decoder_model.req(4'h0, opgen_pkg::MODE_INDEXED, WW, 1'b0, 4'h0, 16'h4766);
    chk(src_addr, 20'h3379C);
    u_decoder_model.dst(4'h5, 1'b0, 4'h0, 16'h0000);
    u_decoder_model.req(4'h3, opgen_pkg::MODE_REG, WW, 1'b0, 4'h0, 16'h0000);
    chk(dst_value, 20'h0FFF0);
    chk(20'(dst_kind), KR);
  endtask : t_index

  task automatic t_indirect();
    u_decoder_model.wr(4'h7, WA, 1'b0, 20'h12345);
    u_decoder_model.req(4'h7, opgen_pkg::MODE_INDIRECT, WW, 1'b0, 4'h0, 16'h0000);
    chk(src_addr, 20'h12345);
    chk(20'(src_kind), KM);
    for (int w = 0; w < 3; w++) begin
      u_decoder_model.req(4'h7, opgen_pkg::MODE_AUTOINC, wl[w], 1'b0, 4'h0, 16'h0000);
    end
    chk(src_addr, 20'h12348);
    rd(4'h7, WA, 20'h1234C);
    u_decoder_model.wr(4'h0, WA, 1'b0, 20'h01000);
    u_decoder_model.req(4'h0, opgen_pkg::MODE_AUTOINC, WB, 1'b0, 4'h0, 16'h1234);
    chk(src_value, 20'h00034);
    chk(20'(src_kind), KC);
    u_decoder_model.req(4'h0, opgen_pkg::MODE_AUTOINC, WA, 1'b1, 4'h5, 16'h6789);
    chk(src_value, 20'h56789);
    repeat (2) @(posedge clk);
    #1;
    chk(pc_value, 20'h01004);
  endtask : t_indirect

  // ==========================================================
  // clock, reset, sequence and hang guard
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      print_verdict();
    end
  end

  initial begin
    arst_n = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(pc_value | src_value | dst_addr | 20'(resp_valid), 20'h00000);
    arst_n <= 1'b1;
    t_width();
    t_const();
    t_index();
    t_indirect();
    print_verdict();
  end
endmodule : tb
